// [config_word_consts.svh]
// constants: offsets, field positions, reset values and timing counts
`ifndef CONFIG_WORD_CONSTS_SVH
`define CONFIG_WORD_CONSTS_SVH

// ***************************
// register byte offsets
// ***************************
`define CFG_WATCHDOG_OFS   12'h000
`define CFG_AUX_OFS        12'h004
`define CFG_POWER_ON_OFS   12'h008
`define CFG_GEN_OFS        12'h00C
`define CFG_STATUS_OFS     12'h010

// ***************************
// watchdog_config fields
// ***************************
`define WD_POST_LSB        0
`define WD_POST_MSB        3
`define WD_PRESCALE_BIT    4
`define WD_LOCK_WAIT_BIT   5
`define WD_WIN_DIS_BIT     6

// ***************************
// segment protect fields (aux and general)
// ***************************
`define SEG_WP_N_BIT       0
`define SEG_CP_N_BIT       1
`define SEG_KEY_LSB        2
`define SEG_KEY_MSB        3
`define SEG_KEY_OPEN       2'h0
`define SEG_KEY_CLOSED     2'h3

// ***************************
// power_on_config fields
// ***************************
`define POR_SEL_LSB        0
`define POR_SEL_MSB        2
`define POR_BROWNOUT_BIT   3
`define POR_I2C1_BIT       4
`define POR_I2C2_BIT       5

// ***************************
// status fields
// ***************************
`define ST_AUX_LOCK_BIT    0
`define ST_POR_DONE_BIT    1
`define ST_POR_BUSY_BIT    2
`define ST_LOADED_BIT      3

// ***************************
// reset values
// ***************************
`define CFG_REG_RST        8'h00
`define AUX_ERASED_VAL     8'h03

// ***************************
// watchdog ratios
// ***************************
`define WD_PRE_DIV_HI      8'h80
`define WD_PRE_DIV_LO      8'h20

// ***************************
// timing
// ***************************
`define MCLK_FREQ_KHZ      250000
`define POR_BASE_TIME_MS   2
`define POR_BASE_CYCLES    (`POR_BASE_TIME_MS * `MCLK_FREQ_KHZ)

`endif

// [config_word_pkg.sv]
// types shared by the configuration decoder files
package config_word_pkg;

  typedef enum logic [1:0] {
    POR_IDLE,
    POR_COUNT,
    POR_DONE
  } por_state_t;

endpackage

// [wd_ratio_decode.sv]
// registered decode of watchdog prescale and postscale ratios
`timescale 1ns/100ps
`default_nettype none
`include "config_word_consts.svh"

module wd_ratio_decode #(
  parameter int POST_W = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  ce,
  input  wire logic                  prescaleSel,
  input  wire logic [POST_W-1:0]     postscaleSel,
  output logic      [7:0]            prescaleDiv,
  output logic      [(1<<POST_W)-1:0] postscaleDiv
);

  logic [7:0]             prescale_next;
  logic [(1<<POST_W)-1:0] postscale_next;

  assign prescale_next = prescaleSel ? `WD_PRE_DIV_HI : `WD_PRE_DIV_LO;

  // ratio is two to the code
  for (genvar i = 0; i < (1 << POST_W); i++) begin : g_post
    assign postscale_next[i] = (postscaleSel == POST_W'(i));
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prescaleDiv  <= `WD_PRE_DIV_LO;
      postscaleDiv <= '0;
    end else if (ce) begin
      prescaleDiv  <= prescale_next;
      postscaleDiv <= postscale_next;
    end
  end

endmodule // wd_ratio_decode
`default_nettype wire

// [por_timer.sv]
// power-on reset delay timer
`timescale 1ns/100ps
`default_nettype none
`include "config_word_consts.svh"

module por_timer #(
  parameter int unsigned BASE_CYCLES = `POR_BASE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [2:0] sel,
  output logic            active,
  output logic            done
);

  config_word_pkg::por_state_t state_reg;
  config_word_pkg::por_state_t state_next;
  logic [31:0]                 count_reg;
  logic [31:0]                 count_next;
  logic [31:0]                 target;
  logic                        expired;

  assign target  = (sel == 3'h0) ? 32'h0000_0000 : (32'(BASE_CYCLES) << (sel - 3'h1));
  assign expired = (count_reg + 32'h0000_0001) >= target;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      config_word_pkg::POR_IDLE: begin
        count_next = 32'h0000_0000;
        if (start) state_next = (sel == 3'h0) ? config_word_pkg::POR_DONE : config_word_pkg::POR_COUNT;
      end
      config_word_pkg::POR_COUNT: begin
        count_next = count_reg + 32'h0000_0001;
        if (expired) state_next = config_word_pkg::POR_DONE;
      end
      config_word_pkg::POR_DONE: begin
        count_next = count_reg;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= config_word_pkg::POR_IDLE;
      count_reg <= 32'h0000_0000;
    end else if (ce) begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      active <= 1'b0;
      done   <= 1'b0;
    end else if (ce) begin
      active <= (state_next == config_word_pkg::POR_COUNT);
      done   <= (state_next == config_word_pkg::POR_DONE);
    end
  end

endmodule // por_timer
`default_nettype wire

// [config_word_decoder.sv]
// configuration word decoder with apb register access
//
// Overview of operation
// - window-disable set gives non-window watchdog, clear gives window mode.
// - lock-wait set holds a switch to pll until pll lock.
// - prescale select set divides by 128, clear divides by 32.
// - postscale code n selects ratio one to two to the n.
// - por delay is 2 ms doubled per code step, zero disables.
// - brown-out detector enabled when its enable field is one.
// - second i2c port uses primary pins when its select is one.
// - first i2c port uses primary pins when its select is one.
// - key mismatch code-protects aux segment until bulk erase.
// - aux code-protect field one means not code protected.
// - aux write-protect field one means writes accepted.
// - aux register modifiable only with all protection off and keys zero.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "config_word_consts.svh"

module config_word_decoder #(
  parameter int          ADDR_W          = 12,
  parameter int unsigned POR_BASE_CYCLES = `POR_BASE_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        nvWatchdog,
  input  wire logic [7:0]        nvAuxProtect,
  input  wire logic [7:0]        nvPowerOn,
  input  wire logic [7:0]        nvGenProtect,
  input  wire logic              bulkErase,
  input  wire logic              clkSwitchReq,
  input  wire logic              clkSwitchToPll,
  input  wire logic              pllLocked,
  output logic                   clkSwitchGo,
  output logic                   wdWindowMode,
  output logic      [7:0]        wdPrescaleDiv,
  output logic      [15:0]       wdPostscaleDiv,
  output logic                   porTimerActive,
  output logic                   porTimerDone,
  output logic                   brownoutEnable,
  output logic                   i2c1Primary,
  output logic                   i2c2Primary,
  output logic                   auxCodeProtected,
  output logic                   auxWriteProtected,
  output logic                   auxLocked
);

  // ***************************
  // key checks: lock key match on aux only, open test shared by both segments
  // ***************************
  // required key for protect fields
  function automatic logic keyMatches(input logic [7:0] seg);
    logic [1:0] want;
    want = (seg[`SEG_WP_N_BIT] && seg[`SEG_CP_N_BIT]) ? `SEG_KEY_OPEN : `SEG_KEY_CLOSED;
    return seg[`SEG_KEY_MSB:`SEG_KEY_LSB] == want;
  endfunction

  function automatic logic segmentOpen(input logic [7:0] seg);
    return seg[`SEG_WP_N_BIT] && seg[`SEG_CP_N_BIT] &&
           (seg[`SEG_KEY_MSB:`SEG_KEY_LSB] == `SEG_KEY_OPEN);
  endfunction

  // ***************************
  // state
  // ***************************
  logic [7:0] watchdog_config_reg;
  logic [7:0] watchdog_config_next;
  logic [7:0] aux_segment_protect_reg;
  logic [7:0] aux_segment_protect_next;
  logic [7:0] power_on_config_reg;
  logic [7:0] power_on_config_next;
  logic [7:0] gen_protect_reg;
  logic [7:0] gen_protect_next;
  logic       loaded_reg;
  logic       auxLock_reg;
  logic       auxLock_next;
  logic       dataOk_reg;
  logic       dataOk_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // ***************************
  // apb decode
  // ***************************
  logic        setupPhase;
  logic        accessPhase;
  logic        xferDone;
  logic        hitWatchdog;
  logic        hitAux;
  logic        hitPowerOn;
  logic        hitGen;
  logic        hitStatus;
  logic        mapped;
  logic        readOnlyHit;
  logic        modifyOk;
  logic        auxDenied;
  logic        lowLane;
  logic        wrWatchdog;
  logic        wrAux;
  logic        wrPowerOn;
  logic        loadNow;
  logic [7:0]  statusVal;
  logic [7:0]  readByte;

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign pready      = ce && dataOk_reg;
  assign xferDone    = accessPhase && pready;

  assign hitWatchdog = paddr == ADDR_W'(`CFG_WATCHDOG_OFS);
  assign hitAux      = paddr == ADDR_W'(`CFG_AUX_OFS);
  assign hitPowerOn  = paddr == ADDR_W'(`CFG_POWER_ON_OFS);
  assign hitGen      = paddr == ADDR_W'(`CFG_GEN_OFS);
  assign hitStatus   = paddr == ADDR_W'(`CFG_STATUS_OFS);
  assign mapped      = hitWatchdog || hitAux || hitPowerOn || hitGen || hitStatus;
  assign readOnlyHit = hitGen || hitStatus;

  assign modifyOk  = segmentOpen(aux_segment_protect_reg) && segmentOpen(gen_protect_reg) && !auxLock_reg;
  assign auxDenied = hitAux && !modifyOk;
  assign lowLane   = pstrb[0];

  assign pslverr = xferDone && (!mapped || (pwrite && (readOnlyHit || auxDenied)));

  assign wrWatchdog = xferDone && pwrite && lowLane && hitWatchdog;
  assign wrAux      = xferDone && pwrite && lowLane && hitAux && modifyOk;
  assign wrPowerOn  = xferDone && pwrite && lowLane && hitPowerOn;

  assign loadNow = !loaded_reg;

  // ***************************
  // register next values
  // ***************************
  assign watchdog_config_next = loadNow ? nvWatchdog :
                                wrWatchdog ? pwdata[7:0] : watchdog_config_reg;
  assign power_on_config_next = loadNow ? nvPowerOn :
                                wrPowerOn ? pwdata[7:0] : power_on_config_reg;
  assign gen_protect_next     = loadNow ? nvGenProtect : gen_protect_reg;
  // bulk erase leaves the aux segment open and consistent
  assign aux_segment_protect_next = loadNow ? nvAuxProtect :
                                    bulkErase ? `AUX_ERASED_VAL :
                                    wrAux ? pwdata[7:0] : aux_segment_protect_reg;

  assign auxLock_next = (auxLock_reg && !bulkErase) ||
                        !keyMatches(aux_segment_protect_next);

  assign dataOk_next = setupPhase ? 1'b1 : (xferDone ? 1'b0 : dataOk_reg);

  // ***************************
  // read mux
  // ***************************
  assign statusVal = {4'h0, loaded_reg, porTimerActive, porTimerDone, auxLock_reg};
  assign readByte  = hitWatchdog ? watchdog_config_reg :
                     hitAux      ? aux_segment_protect_reg :
                     hitPowerOn  ? power_on_config_reg :
                     hitGen      ? gen_protect_reg :
                     hitStatus   ? statusVal : 8'h00;
  assign prdata_next = setupPhase ? {24'h00_0000, readByte} : prdata_reg;
  assign prdata      = prdata_reg;

  // ***************************
  // registers
  // ***************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_config_reg     <= `CFG_REG_RST;
      aux_segment_protect_reg <= `CFG_REG_RST;
      power_on_config_reg     <= `CFG_REG_RST;
      gen_protect_reg         <= `CFG_REG_RST;
    end else if (ce) begin
      watchdog_config_reg     <= watchdog_config_next;
      aux_segment_protect_reg <= aux_segment_protect_next;
      power_on_config_reg     <= power_on_config_next;
      gen_protect_reg         <= gen_protect_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loaded_reg  <= 1'b0;
      auxLock_reg <= 1'b0;
      dataOk_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (ce) begin
      loaded_reg  <= 1'b1;
      auxLock_reg <= auxLock_next;
      dataOk_reg  <= dataOk_next;
      prdata_reg  <= prdata_next;
    end
  end

  // ***************************
  // decoded outputs
  // ***************************
  logic por_start_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      por_start_reg     <= 1'b0;
      wdWindowMode      <= 1'b0;
      brownoutEnable    <= 1'b0;
      i2c1Primary       <= 1'b0;
      i2c2Primary       <= 1'b0;
      auxCodeProtected  <= 1'b1;
      auxWriteProtected <= 1'b1;
      auxLocked         <= 1'b0;
    end else if (ce) begin
      por_start_reg     <= loadNow;
      wdWindowMode      <= !watchdog_config_next[`WD_WIN_DIS_BIT];
      brownoutEnable    <= power_on_config_next[`POR_BROWNOUT_BIT];
      i2c1Primary       <= power_on_config_next[`POR_I2C1_BIT];
      i2c2Primary       <= power_on_config_next[`POR_I2C2_BIT];
      auxCodeProtected  <= !aux_segment_protect_next[`SEG_CP_N_BIT] || auxLock_next;
      auxWriteProtected <= !aux_segment_protect_next[`SEG_WP_N_BIT] || auxLock_next;
      auxLocked         <= auxLock_next;
    end
  end

  assign clkSwitchGo = clkSwitchReq &&
                       (!clkSwitchToPll || !watchdog_config_reg[`WD_LOCK_WAIT_BIT] || pllLocked);

  // ***************************
  // submodules
  // ***************************
  wd_ratio_decode #(
    .POST_W (4)
  ) u_wd_ratio (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .ce           (ce),
    .prescaleSel  (watchdog_config_next[`WD_PRESCALE_BIT]),
    .postscaleSel (watchdog_config_next[`WD_POST_MSB:`WD_POST_LSB]),
    .prescaleDiv  (wdPrescaleDiv),
    .postscaleDiv (wdPostscaleDiv)
  );

  // timer starts once fields are loaded
  por_timer #(
    .BASE_CYCLES (POR_BASE_CYCLES)
  ) u_por_timer (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .start   (por_start_reg),
    .sel     (power_on_config_reg[`POR_SEL_MSB:`POR_SEL_LSB]),
    .active  (porTimerActive),
    .done    (porTimerDone)
  );

endmodule // config_word_decoder
`default_nettype wire

// [config_word_decoder_checker.sv]
// assertions on the configuration word decoder ports
`timescale 1ns/100ps
`default_nettype none

module config_word_decoder_checker (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        bulkErase,
  input wire logic        clkSwitchReq,
  input wire logic        clkSwitchToPll,
  input wire logic        clkSwitchGo,
  input wire logic        wdWindowMode,
  input wire logic [7:0]  wdPrescaleDiv,
  input wire logic [15:0] wdPostscaleDiv,
  input wire logic        porTimerActive,
  input wire logic        porTimerDone,
  input wire logic        brownoutEnable,
  input wire logic        i2c1Primary,
  input wire logic        i2c2Primary,
  input wire logic        auxCodeProtected,
  input wire logic        auxWriteProtected,
  input wire logic        auxLocked
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ***************************
  // load tracking
  // ***************************
  logic [1:0] loadCnt;
  wire        settled = (loadCnt == 2'h3);
  wire        accWr   = psel & penable & pwrite;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loadCnt <= 2'h0;
    end else if (ce && !settled) begin
      loadCnt <= loadCnt + 2'h1;
    end
  end

  // ***************************
  // assertions
  // ***************************
  a_go_needs_req: assert property (clkSwitchGo |-> clkSwitchReq)
    else $error("switch go without request");
  a_go_no_pll: assert property (clkSwitchReq && !clkSwitchToPll |-> clkSwitchGo)
    else $error("non pll switch held");
  a_pre_ratio: assert property (wdPrescaleDiv == 8'h80 || wdPrescaleDiv == 8'h20)
    else $error("bad prescale ratio");
  a_post_onehot: assert property (settled |-> $onehot(wdPostscaleDiv))
    else $error("postscale not one hot");
  a_lock_protects: assert property (auxLocked |-> auxCodeProtected && auxWriteProtected)
    else $error("locked segment left open");
  a_lock_sticky: assert property (auxLocked && !bulkErase |=> auxLocked)
    else $error("lock cleared without erase");
  a_por_exclusive: assert property (!(porTimerActive && porTimerDone))
    else $error("timer active and done");
  a_por_done_hold: assert property (porTimerDone |=> porTimerDone)
    else $error("timer done dropped");
  a_fields_hold: assert property (settled && !accWr && !$past(accWr) && !$past(accWr, 2) |->
    $stable({wdWindowMode, wdPrescaleDiv, wdPostscaleDiv, brownoutEnable, i2c1Primary, i2c2Primary}))
    else $error("decoded field changed without write");
  a_ready_access: assert property (pready |-> psel && penable && ce)
    else $error("ready outside access phase");

  c_pll_go: cover property (clkSwitchGo && clkSwitchToPll);
  c_locked: cover property (auxLocked);
  c_por_done: cover property ($rose(porTimerDone));
  c_refused: cover property (pready && pslverr);
endmodule // config_word_decoder_checker

bind config_word_decoder config_word_decoder_checker i_config_word_decoder_checker (
  .mclk, .reset_n, .ce, .psel, .penable, .pwrite, .pready, .pslverr, .bulkErase, .clkSwitchReq,
  .clkSwitchToPll, .clkSwitchGo, .wdWindowMode, .wdPrescaleDiv, .wdPostscaleDiv, .porTimerActive,
  .porTimerDone, .brownoutEnable, .i2c1Primary, .i2c2Primary, .auxCodeProtected, .auxWriteProtected,
  .auxLocked
);
`default_nettype wire

// [config_word_decoder_tb.sv]
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
`default_nettype none

module config_word_decoder_tb;
  localparam int         BASE    = 8;
  localparam logic [2:0] POR_SEL = 3'h3;

  logic        mclk = 1'b0, reset_n = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  nvWatchdog = 8'h00, nvAuxProtect = 8'h03, nvPowerOn = 8'h00, nvGenProtect = 8'h03;
  logic        bulkErase = 1'b0, clkSwitchReq = 1'b0, clkSwitchToPll = 1'b0, pllLocked = 1'b0;
  logic [31:0] prdata;
  logic [7:0]  wdPrescaleDiv;
  logic [15:0] wdPostscaleDiv;
  logic        pready, pslverr, clkSwitchGo, wdWindowMode, porTimerActive, porTimerDone;
  logic        brownoutEnable, i2c1Primary, i2c2Primary, auxCodeProtected, auxWriteProtected, auxLocked;
  int          error_cnt = 0, comparisons = 0, n;
  integer      seed = 32'hc063;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  v;

  config_word_decoder #(.POR_BASE_CYCLES(BASE)) i_config_word_decoder (
    .mclk, .reset_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .nvWatchdog, .nvAuxProtect, .nvPowerOn, .nvGenProtect, .bulkErase, .clkSwitchReq, .clkSwitchToPll,
    .pllLocked, .clkSwitchGo, .wdWindowMode, .wdPrescaleDiv, .wdPostscaleDiv, .porTimerActive,
    .porTimerDone, .brownoutEnable, .i2c1Primary, .i2c2Primary, .auxCodeProtected, .auxWriteProtected,
    .auxLocked
  );

  always #2 mclk = ~mclk;

  // ***************************
  // helpers
  // ***************************
  function automatic logic [1:0] exp_key(input logic wp, input logic cp);
    return (wp && cp) ? 2'h0 : 2'h3;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    int k;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d}; pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk("pready", 1, 0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic chk_wd(input logic [7:0] w);
    chk("window mode", !w[6], wdWindowMode);
    chk("prescale", w[4] ? 8'h80 : 8'h20, wdPrescaleDiv);
    chk("postscale", 16'h1 << w[3:0], wdPostscaleDiv);
  endtask

  task automatic chk_po(input logic [7:0] p);
    chk("brownout", p[3], brownoutEnable);
    chk("i2c1 pins", p[4], i2c1Primary);
    chk("i2c2 pins", p[5], i2c2Primary);
  endtask

  task automatic erase;
    bulkErase <= 1'b1;
    @(posedge mclk);
    bulkErase <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // ***************************
  // sequence
  // ***************************
  initial begin
    nvWatchdog <= $random(seed);
    v = $random(seed);
    nvPowerOn <= {2'h0, v[5:4], 1'b1, POR_SEL};
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    n = 0;
    while (porTimerDone !== 1'b1 && n < 1000) begin
      @(posedge mclk);
      n++;
      if (n == 8) chk("por active", 1, porTimerActive);
    end
    chk("por delay", 1, n >= (BASE << (POR_SEL - 1)) && n <= (BASE << (POR_SEL - 1)) + 4);
    chk_wd(nvWatchdog);
    chk_po(nvPowerOn);
    for (int i = 0; i < 20; i++) begin
      v = $random(seed);
      if (i < 16) v[3:0] = i[3:0];
      apb(1'b1, 12'h000, v, 4'hF);
      repeat (2) @(posedge mclk);
      chk_wd(v);
      apb(1'b0, 12'h000, 8'h00, 4'hF);
      chk("watchdog read", {24'h0, v[6:0]}, {rd[31:8], rd[6:0]});
    end
    for (int i = 0; i < 16; i++) begin
      if (i[2:0] == 3'h0) apb(1'b1, 12'h000, {2'h0, i[3], 5'h00}, 4'hF);
      clkSwitchReq <= i[0]; clkSwitchToPll <= i[1]; pllLocked <= i[2];
      repeat (2) @(posedge mclk);
      chk("switch go", i[0] & (!i[1] | !i[3] | i[2]), clkSwitchGo);
    end
    clkSwitchReq <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      apb(1'b1, 12'h008, v, 4'hF);
      repeat (2) @(posedge mclk);
      chk_po(v);
    end
    apb(1'b1, 12'h008, ~v, 4'h0);
    repeat (2) @(posedge mclk);
    chk_po(v);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h004, {4'h0, exp_key(i[0], i[1]), i[1], i[0]}, 4'hF);
      repeat (2) @(posedge mclk);
      chk("aux code prot", !i[1], auxCodeProtected);
      chk("aux write prot", !i[0], auxWriteProtected);
      chk("aux lock", 0, auxLocked);
      if (i != 3) begin
        apb(1'b1, 12'h004, 8'h03, 4'hF);
        chk("aux refused", 1, err);
      end
      erase();
    end
    apb(1'b1, 12'h004, 8'h0F, 4'hF);
    repeat (5) @(posedge mclk);
    chk("mismatch lock", 3'h7, {auxLocked, auxCodeProtected, auxWriteProtected});
    apb(1'b1, 12'h004, 8'h03, 4'hF);
    chk("locked refused", 1, err);
    apb(1'b0, 12'h010, 8'h00, 4'hF);
    chk("status", 32'h0B, rd);
    ce <= 1'b0;
    erase();
    chk("frozen lock", 1, auxLocked);
    ce <= 1'b1;
    erase();
    chk("erase unlock", 0, auxLocked);
    apb(1'b0, 12'h004, 8'h00, 4'hF);
    chk("aux after erase", 32'h03, rd);
    apb(1'b1, 12'h00C, 8'h00, 4'hF);
    chk("gen write refused", 1, err);
    // second reset with the general segment closed
    reset_n <= 1'b0;
    nvGenProtect <= 8'h0C;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(1'b0, 12'h00C, 8'h00, 4'hF);
    chk("gen reload", 32'h0C, rd);
    apb(1'b1, 12'h004, 8'h03, 4'hF);
    chk("gen closed refused", 1, err);
    apb(1'b0, 12'h020, 8'h00, 4'hF);
    chk("unmapped err", 1, err);
    chk("unmapped read", 0, rd);
    give_verdict();
  end

  initial begin
    #200000;
    error_cnt++;
    $display("unexpected timeout: expected end seen hang");
    give_verdict();
  end
endmodule // config_word_decoder_tb
`default_nettype wire
